/* rtl/arb_register_bank.sv */
// Converter register bank: control, status, gain and overrange registers.
`timescale 1ns/1ps

module arb_register_bank #(
   parameter int unsigned DATA_W     = arb_pkg::DATA_W,
   parameter int unsigned ADDR_W     = arb_pkg::ADDR_W,
   // Identity value is arbitrary.
   parameter logic        IDENT_FLAG = 1'b0
)(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // Deframed host write.
   input  wire logic              wr_valid,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   // Start of each output frame and the conversion word for it.
   input  wire logic              output_frame_marker,
   input  wire logic [DATA_W-1:0] conv_data,
   // Device state feeding the status register.
   input  wire logic              filter_settled,
   input  wire logic              low_power_mode,
   input  wire logic              decimate_by_128,
   // Overrange sources.
   input  wire logic [DATA_W-1:0] stage1_data,
   input  wire logic              stage1_valid,
   input  wire logic              mod_full_scale,
   input  wire logic              mod_valid,
   // Word loaded for the serial data out line.
   output logic [DATA_W-1:0]      frame_word,
   output logic                   frame_is_register,
   // Controls to the analog and filter sections.
   output logic                   filter_align_trigger,
   output logic                   power_down_request,
   output logic                   low_power_setting,
   output logic                   reference_bypass,
   output logic                   reference_buffer_disable,
   output logic                   amplifier_disable,
   output logic [DATA_W-1:0]      digital_gain,
   output logic [DATA_W-1:0]      overrange_threshold,
   output logic                   overrange_flag
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (DATA_W != 16)
   begin : g_bad_data
      $error("arb_register_bank: DATA_W must be 16");
   end
   if (ADDR_W < 3)
   begin : g_bad_addr
      $error("arb_register_bank: ADDR_W must be at least 3");
   end

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] device_control_reg;
   logic [DATA_W-1:0] device_control_next;
   logic [DATA_W-1:0] device_status;
   logic [DATA_W-1:0] frame_word_next;
   logic              frame_is_register_next;
   logic              wr_control;
   logic              wr_gain;
   logic              wr_threshold;
   logic              ovr_detect;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] target);
      addr_hit = (a == target);
   endfunction : addr_hit

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   always_comb
   begin
      wr_control   = 1'b0;
      wr_gain      = 1'b0;
      wr_threshold = 1'b0;
      if (!wr_valid)
         wr_control = 1'b0;
      else if (addr_hit(wr_addr, ADDR_W'(arb_pkg::ADDR_CONTROL)))
         wr_control = 1'b1;
      else if (addr_hit(wr_addr, ADDR_W'(arb_pkg::ADDR_GAIN)))
         wr_gain = 1'b1;
      else if (addr_hit(wr_addr, ADDR_W'(arb_pkg::ADDR_THRESHOLD)))
         wr_threshold = 1'b1;
   end

   // ------------------------------------------------------------------
   // Control register with self-clearing bits
   // ------------------------------------------------------------------
   // Read selects drop at the frame that consumes them and the sync bit
   // one cycle after it was stored. A write in the same cycle wins.
   always_comb
   begin
      device_control_next = device_control_reg;
      device_control_next[arb_pkg::CTL_SYNC_BIT] = 1'b0;
      if (output_frame_marker)
      begin
         device_control_next[arb_pkg::CTL_OVERRANGE_READ_SELECT_BIT]  = 1'b0;
         device_control_next[arb_pkg::CTL_RD_GAIN_BIT] = 1'b0;
         device_control_next[arb_pkg::CTL_RD_STAT_BIT] = 1'b0;
      end
      if (wr_control)
         device_control_next = wr_data & arb_pkg::CTL_WRITABLE_MASK;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         device_control_reg <= arb_pkg::CONTROL_RST;
      else
         device_control_reg <= device_control_next;
   end

   // ------------------------------------------------------------------
   // Gain and overrange threshold registers
   // ------------------------------------------------------------------
   // Gain is passed to the filter scaler; 0x8000 there is unity.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         digital_gain <= arb_pkg::GAIN_RST;
      else if (wr_gain)
         digital_gain <= wr_data;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         overrange_threshold <= arb_pkg::THRESHOLD_RST;
      else if (wr_threshold)
         overrange_threshold <= wr_data;
   end

   // ------------------------------------------------------------------
   // Control outputs
   // ------------------------------------------------------------------
   // Power-down only gates the analog side; register contents are kept.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         power_down_request <= 1'b0;
         low_power_setting  <= 1'b0;
         amplifier_disable  <= 1'b0;
      end
      else
      begin
         power_down_request <=
            device_control_reg[arb_pkg::CTL_POWER_DOWN_REQUEST_BIT];
         low_power_setting <=
            device_control_reg[arb_pkg::CTL_LOW_POWER_BIT];
         amplifier_disable <=
            device_control_reg[arb_pkg::CTL_AMPLIFIER_DISABLE_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Reference buffer controls
   // ------------------------------------------------------------------
   // Bypass is gated here so a stray bypass bit can never short a
   // running buffer; the host need not order the two writes.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         reference_bypass         <= 1'b0;
         reference_buffer_disable <= 1'b0;
      end
      else
      begin
         reference_bypass <=
            device_control_reg[arb_pkg::CTL_BYPASS_BIT] &
            device_control_reg[arb_pkg::CTL_REF_OFF_BIT];
         reference_buffer_disable <=
            device_control_reg[arb_pkg::CTL_REF_OFF_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Filter synchronization pulse
   // ------------------------------------------------------------------
   // The stored bit lives one cycle, so each write gives one pulse.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         filter_align_trigger <= 1'b0;
      else
         filter_align_trigger <=
            device_control_reg[arb_pkg::CTL_SYNC_BIT];
   end

   // ------------------------------------------------------------------
   // Overrange detection
   // ------------------------------------------------------------------
   arb_overrange_monitor #(
      .DATA_W         (DATA_W)
   ) u_overrange (
      .ref_clk        (ref_clk),
      .srst           (srst),
      .threshold      (overrange_threshold),
      .stage1_data    (stage1_data),
      .stage1_valid   (stage1_valid),
      .mod_full_scale (mod_full_scale),
      .mod_valid      (mod_valid),
      .overrange      (ovr_detect)
   );

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         overrange_flag <= 1'b0;
      else
         overrange_flag <= ovr_detect;
   end

   // ------------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------------
   // Status is sampled at the marker edge; a flag that moves later is
   // only seen in the next redirected frame.
   always_comb
   begin
      device_status = arb_pkg::STS_FIXED_ONES;
      device_status[arb_pkg::STS_IDENT_BIT]   = IDENT_FLAG;
      device_status[arb_pkg::STS_VALID_BIT]   = filter_settled;
      device_status[arb_pkg::STS_LOWPWR_BIT]  = low_power_mode;
      device_status[arb_pkg::STS_OVR_BIT]     = overrange_flag;
      device_status[arb_pkg::STS_REF_OFF_BIT] =
         reference_buffer_disable;
      device_status[arb_pkg::STS_AMPLIFIER_DISABLE_BIT] = amplifier_disable;
      device_status[arb_pkg::STS_ZERO_BIT]    = 1'b0;
      device_status[arb_pkg::STS_DEC_BIT]     = decimate_by_128;
   end

   // ------------------------------------------------------------------
   // Output frame source selection
   // ------------------------------------------------------------------
   // Only one select is expected per write; if several are set anyway,
   // the highest bit wins rather than mixing words.
   always_comb
   begin
      frame_word_next        = conv_data;
      frame_is_register_next = 1'b0;
      if (device_control_reg[arb_pkg::CTL_OVERRANGE_READ_SELECT_BIT])
      begin
         frame_word_next        = overrange_threshold;
         frame_is_register_next = 1'b1;
      end
      else if (device_control_reg[arb_pkg::CTL_RD_GAIN_BIT])
      begin
         frame_word_next        = digital_gain;
         frame_is_register_next = 1'b1;
      end
      else if (device_control_reg[arb_pkg::CTL_RD_STAT_BIT])
      begin
         frame_word_next        = device_status;
         frame_is_register_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         frame_word        <= '0;
         frame_is_register <= 1'b0;
      end
      else if (output_frame_marker)
      begin
         frame_word        <= frame_word_next;
         frame_is_register <= frame_is_register_next;
      end
   end

endmodule : arb_register_bank

/* rtl/arb_pkg.sv */
// Constants shared by the converter register bank and its overrange monitor.
package arb_pkg;

   // ------------------------------------------------------------------
   // Widths and register addresses
   // ------------------------------------------------------------------
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 16;

   localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_GAIN      = 16'h0004;
   localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 16'h0005;

   // ------------------------------------------------------------------
   // Reset values and the unity gain code
   // ------------------------------------------------------------------
   localparam logic [DATA_W-1:0] CONTROL_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] GAIN_RST      = 16'hA000;
   localparam logic [DATA_W-1:0] THRESHOLD_RST = 16'hCCCC;
   localparam logic [DATA_W-1:0] GAIN_UNITY    = 16'h8000;

   // ------------------------------------------------------------------
   // Control register bit positions
   // ------------------------------------------------------------------
   localparam int unsigned CTL_OVERRANGE_READ_SELECT_BIT    = 14;
   localparam int unsigned CTL_RD_GAIN_BIT   = 13;
   localparam int unsigned CTL_RD_STAT_BIT   = 11;
   localparam int unsigned CTL_SYNC_BIT      = 9;
   localparam int unsigned CTL_BYPASS_BIT    = 7;
   localparam int unsigned CTL_POWER_DOWN_REQUEST_BIT  = 3;
   localparam int unsigned CTL_LOW_POWER_BIT = 2;
   localparam int unsigned CTL_REF_OFF_BIT   = 1;
   localparam int unsigned CTL_AMPLIFIER_DISABLE_BIT   = 0;

   // Bits that store a value; all others are always held at zero.
   localparam logic [DATA_W-1:0] CTL_WRITABLE_MASK = 16'h6A8F;

   // ------------------------------------------------------------------
   // Status register bit positions and fixed pattern
   // ------------------------------------------------------------------
   localparam int unsigned STS_IDENT_BIT   = 15;
   localparam int unsigned STS_VALID_BIT   = 10;
   localparam int unsigned STS_LOWPWR_BIT  = 9;
   localparam int unsigned STS_OVR_BIT     = 8;
   localparam int unsigned STS_REF_OFF_BIT = 4;
   localparam int unsigned STS_AMPLIFIER_DISABLE_BIT = 3;
   localparam int unsigned STS_ZERO_BIT    = 2;
   localparam int unsigned STS_DEC_BIT     = 0;

   // Constant ones at bits 14, 11 and 6.
   localparam logic [DATA_W-1:0] STS_FIXED_ONES = 16'h4840;

   // ------------------------------------------------------------------
   // Overrange run length at the modulator rate
   // ------------------------------------------------------------------
   localparam int unsigned OVR_RUN_LIMIT = 4;
   localparam int unsigned OVR_RUN_W     = 3;

endpackage : arb_pkg

/* rtl/arb_overrange_monitor.sv */
// Overrange detector: threshold compare and full-scale run counter.
`timescale 1ns/1ps

module arb_overrange_monitor #(
   parameter int unsigned DATA_W = arb_pkg::DATA_W
)(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic [DATA_W-1:0] threshold,
   input  wire logic [DATA_W-1:0] stage1_data,
   input  wire logic              stage1_valid,
   input  wire logic              mod_full_scale,
   input  wire logic              mod_valid,
   output logic                   overrange
);

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   if (DATA_W < 2)
   begin : g_bad_width
      $error("arb_overrange_monitor: DATA_W must be at least 2");
   end

   logic [DATA_W-1:0]           magnitude;
   logic                        above_th_reg;
   logic [arb_pkg::OVR_RUN_W-1:0] run_reg;

   // Stage output is two's complement; the most negative code stays 0x8000, its unsigned magnitude.
   always_comb
   begin
      magnitude = stage1_data[DATA_W-1] ? (~stage1_data + 1'b1)
                                        : stage1_data;
   end

   // ------------------------------------------------------------------
   // Threshold compare on the first decimation stage, before any gain
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         above_th_reg <= 1'b0;
      else if (stage1_valid)
         above_th_reg <= (magnitude > threshold);
   end

   // ------------------------------------------------------------------
   // Consecutive full-scale samples at the modulator rate
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         run_reg <= '0;
      else if (mod_valid)
      begin
         if (!mod_full_scale)
            run_reg <= '0;
         else if (run_reg <= arb_pkg::OVR_RUN_W'(arb_pkg::OVR_RUN_LIMIT))
            run_reg <= run_reg + 1'b1;
      end
   end

   // The run path bypasses the decimator so a hard overload shows at once.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         overrange <= 1'b0;
      else
         overrange <= above_th_reg |
            (run_reg > arb_pkg::OVR_RUN_W'(arb_pkg::OVR_RUN_LIMIT));
   end

endmodule : arb_overrange_monitor

/* testbench/arb_host_model.sv */
// Host controller model: register writes and output frame requests.
`timescale 1ns/1ps

module arb_host_model (
   input  wire logic   ref_clk,
   output logic        wr_valid,
   output logic [15:0] wr_addr,
   output logic [15:0] wr_data,
   output logic        output_frame_marker,
   output logic [15:0] conv_data
);
   initial
   begin
      wr_valid = 1'b0;
      wr_addr = 16'h0000;
      wr_data = 16'h0000;
      output_frame_marker = 1'b0;
      conv_data = 16'h0000;
   end

   // Idle lines show the inverse so stale data is never mistaken for new.
   task automatic write_reg(input logic [15:0] addr,
                            input logic [15:0] data,
                            input bit          keep = 1'b0);
      wr_valid = 1'b1;
      wr_addr = addr;
      // Only the highest read select is ever sent.
      wr_data = data[14] ? data & 16'hD7FF :
                data[13] ? data & 16'hF7FF : data;
      @(posedge ref_clk);
      #1;
      // A kept strobe lets the next call follow on the very next edge.
      if (!keep)
      begin
         wr_valid = 1'b0;
         wr_addr = ~addr;
         wr_data = ~data;
      end
   endtask : write_reg

   task automatic frame(input logic [15:0] word,
                        input bit          keep = 1'b0);
      output_frame_marker = 1'b1;
      conv_data = word;
      @(posedge ref_clk);
      #1;
      if (!keep)
      begin
         output_frame_marker = 1'b0;
         conv_data = ~word;
      end
   endtask : frame
endmodule : arb_host_model

/* testbench/arb_register_bank_chk.sv */
// Port-level assertions for the register bank.
`timescale 1ns/1ps

module arb_register_bank_chk #(
   parameter int unsigned DATA_W     = arb_pkg::DATA_W,
   parameter int unsigned ADDR_W     = arb_pkg::ADDR_W,
   parameter logic        IDENT_FLAG = 1'b0
)(
   input wire logic              ref_clk,
   input wire logic              srst,
   input wire logic              wr_valid,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              output_frame_marker,
   input wire logic [DATA_W-1:0] conv_data,
   input wire logic              filter_settled,
   input wire logic              mod_full_scale,
   input wire logic              mod_valid,
   input wire logic [DATA_W-1:0] frame_word,
   input wire logic              frame_is_register,
   input wire logic              filter_align_trigger,
   input wire logic              power_down_request,
   input wire logic              reference_bypass,
   input wire logic              reference_buffer_disable,
   input wire logic              amplifier_disable,
   input wire logic [DATA_W-1:0] digital_gain,
   input wire logic [DATA_W-1:0] overrange_threshold,
   input wire logic              overrange_flag
);
   logic ctl_wr, gain_wr, thr_wr, stat_wr, sync_wr, sel_pend_reg;
   assign ctl_wr = wr_valid && wr_addr == arb_pkg::ADDR_CONTROL;
   assign gain_wr = wr_valid && wr_addr == arb_pkg::ADDR_GAIN;
   assign thr_wr = wr_valid && wr_addr == arb_pkg::ADDR_THRESHOLD;
   assign stat_wr = ctl_wr && wr_data[11] && !wr_data[14] && !wr_data[13];
   assign sync_wr = ctl_wr && wr_data[9];

   // A pending read select means the next frame may be redirected.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         sel_pend_reg <= 1'b0;
      else if (ctl_wr && (wr_data & 16'h6800) != 16'h0000)
         sel_pend_reg <= 1'b1;
      else if (output_frame_marker)
         sel_pend_reg <= 1'b0;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_trigger_one_cycle:
      assert property (filter_align_trigger |-> $past(sync_wr, 2))
      else $error("align trigger without a sync write two cycles back");
   a_sync_starts:
      assert property (ctl_wr && wr_data[9] |-> ##2 filter_align_trigger)
      else $error("align trigger missing after write");
   a_bypass_gated:
      assert property (reference_bypass |-> reference_buffer_disable)
      else $error("bypass while buffer on");
   a_ctl_levels:
      assert property (ctl_wr |-> ##2 {power_down_request,
         reference_buffer_disable, amplifier_disable} ==
         {$past(wr_data[3], 2), $past(wr_data[1], 2), $past(wr_data[0], 2)})
      else $error("control level outputs wrong");
   a_gain_write:
      assert property (gain_wr ##1 !gain_wr |-> ##1
         digital_gain == $past(wr_data, 2))
      else $error("gain register not written");
   a_thresh_write:
      assert property (thr_wr ##1 !thr_wr |-> ##1
         overrange_threshold == $past(wr_data, 2))
      else $error("threshold register not written");
   a_status_frame:
      assert property (stat_wr ##1 (!wr_valid && !output_frame_marker)
         ##1 output_frame_marker |=> frame_is_register &&
         (frame_word & 16'h4844) == 16'h4840 &&
         frame_word[15] == IDENT_FLAG &&
         frame_word[10] == $past(filter_settled))
      else $error("status frame wrong");
   a_conv_frame:
      assert property (output_frame_marker && !sel_pend_reg |=>
         !frame_is_register && frame_word == $past(conv_data))
      else $error("conversion frame wrong");
   a_ovr_run:
      assert property ((mod_valid && mod_full_scale)[*5] |-> ##3
         overrange_flag)
      else $error("overrange run not flagged");

   c_sync: cover property (filter_align_trigger);
   c_redirect: cover property (output_frame_marker && sel_pend_reg);
   c_ovr: cover property ($rose(overrange_flag));
endmodule : arb_register_bank_chk

bind arb_register_bank arb_register_bank_chk #(.DATA_W(DATA_W),
   .ADDR_W(ADDR_W), .IDENT_FLAG(IDENT_FLAG)) u_chk (
   .ref_clk(ref_clk), .srst(srst), .wr_valid(wr_valid),
   .wr_addr(wr_addr), .wr_data(wr_data),
   .output_frame_marker(output_frame_marker), .conv_data(conv_data),
   .filter_settled(filter_settled), .mod_full_scale(mod_full_scale),
   .mod_valid(mod_valid), .frame_word(frame_word),
   .frame_is_register(frame_is_register),
   .filter_align_trigger(filter_align_trigger),
   .power_down_request(power_down_request),
   .reference_bypass(reference_bypass),
   .reference_buffer_disable(reference_buffer_disable),
   .amplifier_disable(amplifier_disable), .digital_gain(digital_gain),
   .overrange_threshold(overrange_threshold),
   .overrange_flag(overrange_flag));

/* testbench/arb_register_bank_tb.sv */
// Self-checking bench for the converter register bank.
`timescale 1ns/1ps

module arb_register_bank_tb;
   logic        ref_clk, srst, wr_valid, output_frame_marker;
   logic [15:0] wr_addr, wr_data, conv_data, stage1_data, frame_word;
   logic        filter_settled, low_power_mode, decimate_by_128;
   logic        stage1_valid, mod_full_scale, mod_valid, frame_is_register;
   logic        filter_align_trigger, power_down_request, low_power_setting;
   logic        reference_bypass, reference_buffer_disable;
   logic        amplifier_disable, overrange_flag;
   logic [15:0] digital_gain, overrange_threshold;
   logic [15:0] sel [4];
   logic [15:0] exp_w [4];
   int          n_fail, num_checks, cycles, pulses;

   arb_host_model host (.ref_clk(ref_clk), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data),
      .output_frame_marker(output_frame_marker), .conv_data(conv_data));

   arb_register_bank uut (.ref_clk(ref_clk), .srst(srst),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
      .output_frame_marker(output_frame_marker), .conv_data(conv_data),
      .filter_settled(filter_settled), .low_power_mode(low_power_mode),
      .decimate_by_128(decimate_by_128), .stage1_data(stage1_data),
      .stage1_valid(stage1_valid), .mod_full_scale(mod_full_scale),
      .mod_valid(mod_valid), .frame_word(frame_word),
      .frame_is_register(frame_is_register),
      .filter_align_trigger(filter_align_trigger),
      .power_down_request(power_down_request),
      .low_power_setting(low_power_setting),
      .reference_bypass(reference_bypass),
      .reference_buffer_disable(reference_buffer_disable),
      .amplifier_disable(amplifier_disable), .digital_gain(digital_gain),
      .overrange_threshold(overrange_threshold),
      .overrange_flag(overrange_flag));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Whole run needs well under a thousand cycles.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         results();
      end
   end

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk(input string name, input logic [15:0] exp_v,
                      input logic [15:0] got);
      num_checks++;
      if (got !== exp_v)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", name, exp_v, got);
      end
   endtask : chk

   function automatic logic [15:0] ctl_bits();
      return {10'h000, power_down_request, low_power_setting,
              reference_bypass, reference_buffer_disable,
              amplifier_disable, filter_align_trigger};
   endfunction : ctl_bits

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      {filter_settled, low_power_mode, decimate_by_128} = 3'h0;
      {stage1_valid, mod_full_scale, mod_valid} = 3'h0;
      stage1_data = 16'h0000;
      sel = '{16'h4004, 16'h2004, 16'h0807, 16'h0800};
      exp_w = '{16'h0F0F, 16'h1234, 16'h4E59, 16'h4840};
      repeat (6) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      chk("gain_rst", 16'hA000, digital_gain);
      chk("thr_rst", 16'hCCCC, overrange_threshold);
      chk("ctl_rst", 16'h0000, ctl_bits());
      host.frame(16'h1357);
      chk("conv_rst", 16'h1357, frame_word);
      $display("test reset done");

      host.write_reg(16'h0001, 16'h008F);
      tick(2);
      chk("ctl_on", 16'h003E, ctl_bits());
      host.write_reg(16'h0001, 16'h0080);
      tick(2);
      chk("bypass_buf_on", 16'h0000, ctl_bits());
      $display("test control done");

      // Back to back writes, the last one to an unmapped address.
      host.write_reg(16'h0004, 16'h1234, 1'b1);
      host.write_reg(16'h0005, 16'h0F0F, 1'b1);
      host.write_reg(16'h0002, 16'hFFFF);
      tick(2);
      chk("gain_wr", 16'h1234, digital_gain);
      chk("thr_wr", 16'h0F0F, overrange_threshold);
      for (int i = 0; i < 4; i++)
      begin
         {filter_settled, low_power_mode, decimate_by_128} = {3{i != 3}};
         host.write_reg(16'h0001, sel[i]);
         tick(1);
         host.frame(16'h5555, 1'b1);
         chk("redirect", exp_w[i], frame_word);
         chk("redir_flag", 16'h0001, frame_is_register);
         host.frame(16'h2AAA);
         chk("back_to_conv", 16'h2AAA, frame_word);
      end
      $display("test read select done");

      host.write_reg(16'h0001, 16'h0200);
      pulses = 0;
      repeat (6)
      begin
         if (filter_align_trigger === 1'b1)
            pulses++;
         tick(1);
      end
      chk("sync_pulses", 16'h0001, pulses[15:0]);
      $display("test sync done");

      // Gain below unity would hide the excess if applied first.
      stage1_data = 16'h1000;
      stage1_valid = 1'b1;
      tick(1);
      stage1_valid = 1'b0;
      tick(3);
      chk("ovr_cmp", 16'h0001, overrange_flag);
      stage1_data = 16'h0100;
      stage1_valid = 1'b1;
      tick(1);
      stage1_valid = 1'b0;
      tick(3);
      chk("ovr_clear", 16'h0000, overrange_flag);
      {mod_valid, mod_full_scale} = 2'h3;
      tick(4);
      mod_full_scale = 1'b0;
      tick(2);
      chk("ovr_run4", 16'h0000, overrange_flag);
      mod_full_scale = 1'b1;
      tick(7);
      chk("ovr_run5", 16'h0001, overrange_flag);
      {mod_valid, mod_full_scale} = 2'h0;
      $display("test overrange done");
      results();
   end
endmodule : arb_register_bank_tb
